// ===== hdl/host_bus_pins.sv
// Host bus handshake, vector, interrupt and port pin muxing for the dual serial controller
//
// Overview of operation
// - Data bus drives only in a read with chip select low or in an interrupt acknowledge cycle.
// - Transfer acknowledge goes low in every read, write or vector cycle.
// - Interrupt acknowledge puts the vector on the bus and asserts acknowledge.
// - Open-drain interrupt request pulls low while any unmasked condition is true.
// - Reset clears status, mask and port registers and parks outputs high.
// - Serial characters shift least significant bit first both ways.
// - Transmit output sits at mark when disabled, idle or in local loopback.
// - External transmit clock: serial data changes on its falling edge.
// - External receive clock: serial data sampled on its rising edge.
// - Input pins 0 and 1 are plain inputs or clear-to-send for A and B.
// - Input pin 2 is a plain input or the counter external clock.
// - Input pins 3 to 6 are plain inputs or the four external serial clocks.
// - Output pins 0 and 1 are plain outputs or request-to-send, auto-droppable.
// - Output pin 2 is plain, A transmit 1x or 16x clock, or A receive 1x clock.
// - Output pin 3 is plain, open-drain timer output, or B 1x clock.
// - Output pins 4 to 7 are plain or open-drain interrupt outputs.
// - Bus strap high or open selects this acknowledge-style bus.
// - Write completes and data is captured at acknowledge low or chip select high.
// - Acknowledge floats once chip select or interrupt acknowledge returns high.
`timescale 1ns/1ps
`default_nettype none
module host_bus_pins
    import host_pins_pkg::*;
#(
    parameter int SYNC_STAGES = 2
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reset_in_n,
    input wire logic bus_mode_strap,
    // Host bus
    input wire logic chip_select_n,
    input wire logic read_write_select,
    input wire logic irq_ack_in_n,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic transfer_ack_n_out,
    output logic transfer_ack_n_oe,
    output logic irq_request_n_out,
    output logic irq_request_n_oe,
    // Core register side
    output logic wr_strobe,
    output logic rd_strobe,
    output logic [ADDR_W-1:0] reg_addr,
    output logic [DATA_W-1:0] wr_data,
    input wire logic [DATA_W-1:0] rd_data,
    input wire logic [DATA_W-1:0] irq_vector,
    // Interrupt state
    input wire logic [IRQ_W-1:0] irq_status_reg,
    input wire logic [IRQ_W-1:0] irq_mask_reg,
    // Port configuration
    input wire logic [OUT_PORT_W-1:0] out_port_value_reg,
    input wire port_func_s out_port_function_reg,
    input wire logic rts_a_auto_drop,
    input wire logic rts_b_auto_drop,
    input wire logic tx_a_clk16,
    input wire logic tx_a_clk1,
    input wire logic rx_a_clk1,
    input wire logic tx_b_clk1,
    input wire logic rx_b_clk1,
    input wire logic ct_output,
    // Port pins
    input wire logic [IN_PORT_W-1:0] in_port,
    output logic [OUT_PORT_W-1:0] out_port_out,
    output logic [OUT_PORT_W-1:0] out_port_oe,
    // Decoded input port functions
    output logic chan_a_clear_to_send_n,
    output logic chan_b_clear_to_send_n,
    output logic ct_ext_clock,
    output logic chan_a_transmit_ext_clock,
    output logic chan_a_receive_ext_clock,
    output logic chan_b_transmit_ext_clock,
    output logic chan_b_receive_ext_clock,
    output logic [IN_PORT_W-1:0] in_port_value,
    output logic bus_mode_ack
);

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_WAIT = 4'b0010,
        ST_ACK = 4'b0100,
        ST_HOLD = 4'b1000
    } bus_state_e;

    host_req_s sync_stage [SYNC_STAGES];
    host_req_s req;
    host_req_s next_req;
    bus_state_e state;
    bus_state_e next_state;
    logic [DATA_W-1:0] data_out_q;
    logic [DATA_W-1:0] next_data_out;
    logic [DATA_W-1:0] wr_data_q;
    logic [DATA_W-1:0] next_wr_data;
    logic [DATA_W-1:0] held_data;
    logic [DATA_W-1:0] next_held_data;
    logic data_oe_q;
    logic next_data_oe;
    logic wr_strobe_q;
    logic next_wr_strobe;
    logic rd_strobe_q;
    logic next_rd_strobe;
    logic [ADDR_W-1:0] reg_addr_q;
    logic [ADDR_W-1:0] next_reg_addr;
    logic is_write;
    logic cycle_req;
    logic any_reset;
    logic bus_mode;
    logic next_bus_mode;

    // Chip reset pin and core reset both park the block
    assign any_reset = rst | ~reset_in_n;

    // Strap caught by a clock edge, never loaded by the reset itself
    always_comb begin
        next_bus_mode = bus_mode_strap;
    end
    always_ff @(posedge core_clk) begin
        bus_mode <= next_bus_mode;
    end
    assign bus_mode_ack = bus_mode;

    // Synchroniser: only the last stage is decoded
    always_comb begin
        next_req = '{chip_select_n, read_write_select, irq_ack_in_n, addr};
    end
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                sync_stage[i] <= '{1'b1, 1'b1, 1'b1, '0};
            end
        end else begin
            sync_stage[0] <= next_req;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                sync_stage[i] <= sync_stage[i-1];
            end
        end
    end
    assign req = sync_stage[SYNC_STAGES-1];

    assign is_write = ~req.read_write_select & req.irq_ack_in_n;
    // Strap low selects the other bus style; this block then stays silent
    assign cycle_req = bus_mode & (~req.chip_select_n | ~req.irq_ack_in_n);

    // Bus cycle sequencing: one wait cycle for read data, then acknowledge
    always_comb begin
        next_state = state;
        next_data_out = data_out_q;
        next_data_oe = data_oe_q;
        next_wr_data = wr_data_q;
        next_held_data = chip_select_n ? held_data : data_in; // A write may end on select rising
        next_wr_strobe = 1'b0;
        next_rd_strobe = 1'b0;
        next_reg_addr = reg_addr_q;
        case (state)
            ST_IDLE: begin
                if (cycle_req) begin
                    next_reg_addr = req.addr;
                    next_rd_strobe = ~req.chip_select_n & req.read_write_select & req.irq_ack_in_n;
                    next_state = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (!cycle_req) begin
                    next_state = ST_IDLE;
                end else begin
                    if (!req.irq_ack_in_n) begin
                        next_data_out = irq_vector;
                        next_data_oe = 1'b1;
                    end else if (req.read_write_select) begin
                        next_data_out = rd_data;
                        next_data_oe = 1'b1;
                    end else begin
                        next_wr_data = held_data;
                        next_wr_strobe = 1'b1;
                    end
                    next_state = ST_ACK;
                end
            end
            ST_ACK: begin
                next_state = cycle_req ? ST_HOLD : ST_IDLE;
                next_data_oe = cycle_req & data_oe_q;
            end
            ST_HOLD: begin
                if (!cycle_req) begin
                    next_state = ST_IDLE;
                end
            end
            default: next_state = ST_IDLE;
        endcase
        // Host dropping select mid-cycle ends any drive at once
        if (!cycle_req) begin
            next_data_oe = 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            state <= ST_IDLE;
            data_out_q <= REG_CLEAR;
            data_oe_q <= 1'b0;
            wr_data_q <= REG_CLEAR;
            held_data <= REG_CLEAR;
            wr_strobe_q <= 1'b0;
            rd_strobe_q <= 1'b0;
            reg_addr_q <= '0;
        end else begin
            state <= next_state;
            data_out_q <= next_data_out;
            data_oe_q <= next_data_oe;
            wr_data_q <= next_wr_data;
            held_data <= next_held_data;
            wr_strobe_q <= next_wr_strobe;
            rd_strobe_q <= next_rd_strobe;
            reg_addr_q <= next_reg_addr;
        end
    end

    assign data_out = data_out_q;
    // Raw chip select also gates drive so the bus floats without sync delay
    assign data_oe = data_oe_q & ~chip_select_n | data_oe_q & ~irq_ack_in_n;
    assign wr_data = wr_data_q;
    assign wr_strobe = wr_strobe_q;
    assign rd_strobe = rd_strobe_q;
    assign reg_addr = reg_addr_q;

    // Acknowledge is low when driven; the wire floats once the host lets go
    assign transfer_ack_n_out = 1'b0;
    assign transfer_ack_n_oe = (state == ST_ACK || state == ST_HOLD) &
        (~chip_select_n | ~irq_ack_in_n);

    // Interrupt request is open drain
    assign irq_request_n_out = 1'b0;
    assign irq_request_n_oe = ~any_reset & |(irq_status_reg & irq_mask_reg);

    // Input port decoding; every pin also reads back as a plain input
    assign in_port_value = in_port;
    assign chan_a_clear_to_send_n = in_port[IP_CTS_A];
    assign chan_b_clear_to_send_n = in_port[IP_CTS_B];
    assign ct_ext_clock = in_port[IP_CT_CLK];
    assign chan_a_transmit_ext_clock = in_port[IP_TXC_A];
    assign chan_a_receive_ext_clock = in_port[IP_RXC_A];
    assign chan_b_transmit_ext_clock = in_port[IP_TXC_B];
    assign chan_b_receive_ext_clock = in_port[IP_RXC_B];

    // Output port muxing; the value register holds the inverse of the pin
    logic [OUT_PORT_W-1:0] next_port_out;
    logic [OUT_PORT_W-1:0] next_port_oe;
    logic [OUT_PORT_W-1:0] port_out_q;
    logic [OUT_PORT_W-1:0] port_oe_q;
    localparam int IRQ_BIT [4] = '{ISR_RX_A, ISR_RX_B, ISR_TX_A, ISR_TX_B};

    always_comb begin
        next_port_out = ~out_port_value_reg;
        next_port_oe = '1;
        if (out_port_function_reg.rts_a_en) begin
            next_port_out[0] = ~out_port_value_reg[0] | rts_a_auto_drop;
        end
        if (out_port_function_reg.rts_b_en) begin
            next_port_out[1] = ~out_port_value_reg[1] | rts_b_auto_drop;
        end
        case (out_port_function_reg.op2_sel)
            OP2_TX16: next_port_out[2] = tx_a_clk16;
            OP2_TX1: next_port_out[2] = tx_a_clk1;
            OP2_RX1: next_port_out[2] = rx_a_clk1;
            default: next_port_out[2] = ~out_port_value_reg[2];
        endcase
        case (out_port_function_reg.op3_sel)
            OP3_CT: begin
                next_port_out[3] = 1'b0;
                next_port_oe[3] = ~ct_output;
            end
            OP3_TXB1: next_port_out[3] = tx_b_clk1;
            OP3_RXB1: next_port_out[3] = rx_b_clk1;
            default: next_port_out[3] = ~out_port_value_reg[3];
        endcase
        for (int k = 0; k < 4; k++) begin
            if (out_port_function_reg.irq_pin_en[k]) begin
                next_port_out[4+k] = 1'b0;
                next_port_oe[4+k] = irq_status_reg[IRQ_BIT[k]];
            end
        end
    end
    always_ff @(posedge core_clk) begin
        if (any_reset) begin
            port_out_q <= '1;
            port_oe_q <= '1;
        end else begin
            port_out_q <= next_port_out;
            port_oe_q <= next_port_oe;
        end
    end
    assign out_port_out = port_out_q;
    assign out_port_oe = port_oe_q;

    // Acknowledge never drives without a host request behind it
    a_ack_needs_req: assert property (@(posedge core_clk) disable iff (any_reset)
        transfer_ack_n_oe |-> (~chip_select_n | ~irq_ack_in_n) && $past(cycle_req))
        else $error("acknowledge driven without request");

    // Vector appears with acknowledge in an interrupt acknowledge cycle
    a_vector_on_ack: assert property (@(posedge core_clk) disable iff (any_reset)
        (state == ST_ACK && !req.irq_ack_in_n && !irq_ack_in_n) |-> data_oe && data_out == $past(irq_vector))
        else $error("vector missing in acknowledge");

    // Bus floats while chip select and interrupt acknowledge are high
    a_bus_float: assert property (@(posedge core_clk)
        (chip_select_n && irq_ack_in_n) |-> !data_oe)
        else $error("data bus driven while deselected");

    // Write strobe follows a held write request
    a_write_capture: assert property (@(posedge core_clk) disable iff (any_reset)
        wr_strobe |-> $past(state) == ST_WAIT && !$past(req.read_write_select))
        else $error("write strobe without write cycle");

    // Acknowledge arrives within a bounded time of a steady request
    sequence s_steady_cycle;
        bus_mode && !chip_select_n && irq_ack_in_n [*5];
    endsequence
    a_ack_arrives: assert property (@(posedge core_clk) disable iff (any_reset)
        s_steady_cycle |-> ##[0:2] transfer_ack_n_oe)
        else $error("acknowledge late");

    // Interrupt request tracks masked status
    a_irq_level: assert property (@(posedge core_clk) disable iff (any_reset)
        irq_request_n_oe == |(irq_status_reg & irq_mask_reg))
        else $error("interrupt request mismatch");

    // Output pins sit high just after reset
    a_port_reset: assert property (@(posedge core_clk) disable iff (any_reset)
        $past(any_reset) |-> out_port_out == '1)
        else $error("output port not high after reset");

    // Strap low keeps the block from acknowledging
    a_strap_mode: assert property (@(posedge core_clk) disable iff (any_reset)
        !bus_mode [*3] |-> !transfer_ack_n_oe)
        else $error("acknowledge in other bus mode");

endmodule : host_bus_pins
`default_nettype wire

// ===== hdl/host_pins_pkg.sv
// Constants and carriers for the acknowledge-style host bus pin block
package host_pins_pkg;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 4;
    localparam int IN_PORT_W = 7;
    localparam int OUT_PORT_W = 8;
    localparam int IRQ_W = 8;
    // Input port pin assignments
    localparam int IP_CTS_A = 0;
    localparam int IP_CTS_B = 1;
    localparam int IP_CT_CLK = 2;
    localparam int IP_TXC_A = 3;
    localparam int IP_RXC_A = 4;
    localparam int IP_TXC_B = 5;
    localparam int IP_RXC_B = 6;
    // Interrupt status bit positions driven onto output pins 4 to 7
    localparam int ISR_TX_A = 0;
    localparam int ISR_RX_A = 1;
    localparam int ISR_TX_B = 4;
    localparam int ISR_RX_B = 5;
    // Reset values
    localparam logic [7:0] REG_CLEAR = 8'h00;
    localparam logic [7:0] VECTOR_RESET = 8'h0f;
    // Output pin 2 function codes
    localparam logic [1:0] OP2_GPIO = 2'h0;
    localparam logic [1:0] OP2_TX16 = 2'h1;
    localparam logic [1:0] OP2_TX1 = 2'h2;
    localparam logic [1:0] OP2_RX1 = 2'h3;
    // Output pin 3 function codes
    localparam logic [1:0] OP3_GPIO = 2'h0;
    localparam logic [1:0] OP3_CT = 2'h1;
    localparam logic [1:0] OP3_TXB1 = 2'h2;
    localparam logic [1:0] OP3_RXB1 = 2'h3;

    // Host request as seen after synchronisation
    typedef struct packed {
        logic chip_select_n;
        logic read_write_select;
        logic irq_ack_in_n;
        logic [ADDR_W-1:0] addr;
    } host_req_s;

    // Output port function selection
    typedef struct packed {
        logic [1:0] op2_sel;
        logic [1:0] op3_sel;
        logic [3:0] irq_pin_en;
        logic rts_a_en;
        logic rts_b_en;
    } port_func_s;
endpackage : host_pins_pkg

// ===== verif/host_bus_pins_bench.sv
// Self-checking bench for the host bus pin block
`timescale 1ns/1ps
`default_nettype none
module host_bus_pins_bench
    import host_pins_pkg::*;
;
    typedef struct packed {logic [7:0] st; logic [7:0] msk; logic irq; logic [3:0] pins;} row_s;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reset_in_n = 1'b1;
    logic strap = 1'b1;
    logic cs_n, rw, iack_n, ack_oe, ack_out, d_oe, irq_out, irq_oe, wr_s, rd_s, bm_ack;
    logic cts_a, cts_b, ct_clk, txa_c, rxa_c, txb_c, rxb_c, got;
    logic t16 = 1'b1, t1 = 1'b0, r1 = 1'b1, tb1 = 1'b0, rb1 = 1'b1, ct = 1'b0, drop = 1'b0;
    logic [ADDR_W-1:0] a, r_addr, last_wa, last_ra;
    logic [DATA_W-1:0] d_in, d_out, w_data, last_wr, rdat;
    logic [IRQ_W-1:0] st = 8'h00, msk = 8'h00;
    logic [OUT_PORT_W-1:0] opv = 8'ha5, op_out, op_oe;
    logic [IN_PORT_W-1:0] ip = 7'h55, ipv;
    logic [3:0] e2, e3;
    port_func_s fn = '0;
    int n_mismatch = 0, total_checks = 0, n_wr = 0, n_rd = 0, cyc = 0;
    row_s rows [7] = '{'{8'h00, 8'hff, 1'b0, 4'h0}, '{8'h80, 8'h00, 1'b0, 4'h0},
        '{8'h80, 8'h80, 1'b1, 4'h0}, '{8'h02, 8'hff, 1'b1, 4'h1}, '{8'h20, 8'hff, 1'b1, 4'h2},
        '{8'h01, 8'hff, 1'b1, 4'h4}, '{8'h10, 8'hff, 1'b1, 4'h8}};
    // Wire levels: acknowledge has a pull-up, data bus is shared
    wire logic ack_wire = ack_oe ? ack_out : 1'b1;
    wire logic [DATA_W-1:0] d_bus = d_oe ? d_out : d_in;

    always #20 core_clk = ~core_clk;

    host_cpu_model host (.core_clk(core_clk), .ack_wire(ack_wire), .d_bus(d_bus), .chip_select_n(cs_n),
        .read_write_select(rw), .irq_ack_in_n(iack_n), .addr(a), .data_in(d_in));

    host_bus_pins #(.SYNC_STAGES(2)) dut (.core_clk(core_clk), .rst(rst), .reset_in_n(reset_in_n),
        .bus_mode_strap(strap), .chip_select_n(cs_n), .read_write_select(rw), .irq_ack_in_n(iack_n),
        .addr(a), .data_in(d_in), .data_out(d_out), .data_oe(d_oe), .transfer_ack_n_out(ack_out),
        .transfer_ack_n_oe(ack_oe), .irq_request_n_out(irq_out), .irq_request_n_oe(irq_oe),
        .wr_strobe(wr_s), .rd_strobe(rd_s), .reg_addr(r_addr), .wr_data(w_data), .rd_data(8'h3c),
        .irq_vector(8'h7e), .irq_status_reg(st), .irq_mask_reg(msk), .out_port_value_reg(opv),
        .out_port_function_reg(fn), .rts_a_auto_drop(drop), .rts_b_auto_drop(drop), .tx_a_clk16(t16),
        .tx_a_clk1(t1), .rx_a_clk1(r1), .tx_b_clk1(tb1), .rx_b_clk1(rb1), .ct_output(ct), .in_port(ip),
        .out_port_out(op_out), .out_port_oe(op_oe), .chan_a_clear_to_send_n(cts_a),
        .chan_b_clear_to_send_n(cts_b), .ct_ext_clock(ct_clk), .chan_a_transmit_ext_clock(txa_c),
        .chan_a_receive_ext_clock(rxa_c), .chan_b_transmit_ext_clock(txb_c),
        .chan_b_receive_ext_clock(rxb_c), .in_port_value(ipv), .bus_mode_ack(bm_ack));

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] seen);
        total_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic results();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : results

    // Strobe monitor and hang guard; a clean run needs about 100 cycles
    always @(posedge core_clk) begin
        cyc++;
        if (wr_s === 1'b1) begin
            n_wr++;
            last_wr = w_data;
            last_wa = r_addr;
        end
        if (rd_s === 1'b1) begin
            n_rd++;
            last_ra = r_addr;
        end
        if (cyc == 1500) begin
            n_mismatch++;
            results();
        end
    end

    initial begin
        repeat (8) @(negedge core_clk);
        rst = 1'b0;
        // Interrupt request and interrupt pins, one row per case
        fn.irq_pin_en = 4'hf;
        foreach (rows[i]) begin
            st = rows[i].st;
            msk = rows[i].msk;
            repeat (2) @(negedge core_clk);
            check("irq_oe", rows[i].irq, irq_oe);
            check("irq_out", 0, irq_out);
            check("irq_pins_oe", rows[i].pins, op_oe[7:4]);
            check("irq_pins_out", 0, op_out[7:4]);
        end
        // Plain outputs: register value inverted onto the pins
        fn = '0;
        repeat (2) @(negedge core_clk);
        check("gpio_out", 8'h5a, op_out);
        check("gpio_oe", 8'hff, op_oe);
        // Every function code of output pins 2 and 3
        e2 = {r1, t1, t16, ~opv[2]};
        e3 = {rb1, tb1, 1'b0, ~opv[3]};
        for (int i = 0; i < 4; i++) begin
            fn.op2_sel = 2'(i);
            fn.op3_sel = 2'(i);
            repeat (2) @(negedge core_clk);
            check("op2", {1'b1, e2[i]}, {op_oe[2], op_out[2]});
            check("op3", {1'b1, e3[i]}, {op_oe[3], op_out[3]});
        end
        // Open-drain timer output lets go while the timer output is high
        fn.op3_sel = OP3_CT;
        ct = 1'b1;
        repeat (2) @(negedge core_clk);
        check("op3_ct_oe", 0, op_oe[3]);
        // Request-to-send pins go high while auto drop is active
        fn.rts_a_en = 1'b1;
        fn.rts_b_en = 1'b1;
        for (int i = 0; i < 2; i++) begin
            drop = (i == 0);
            repeat (2) @(negedge core_clk);
            check("rts_pins", {1'b1, drop}, op_out[1:0]);
        end
        // Decoded input port functions
        for (int i = 0; i < 2; i++) begin
            ip = i ? 7'h2a : 7'h55;
            #1;
            check("in_dec", ip, {rxb_c, txb_c, rxa_c, txa_c, ct_clk, cts_b, cts_a});
            check("in_val", ip, ipv);
        end
        // Read, write and vector cycles back to back
        host.xfer(1'b0, 1'b1, 4'h5, 8'h00, 20, rdat, got);
        check("rd_ack", 1, got);
        check("rd_data", 8'h3c, rdat);
        check("rd_cnt", {28'h1, 4'h5}, {n_rd[27:0], last_ra});
        check("idle_oe", 0, {ack_oe, d_oe});
        host.xfer(1'b0, 1'b0, 4'ha, 8'hc3, 20, rdat, got);
        check("wr_ack", 1, got);
        check("wr_cap", {20'h1, 4'ha, 8'hc3}, {n_wr[19:0], last_wa, last_wr});
        check("wr_oe", 0, {ack_oe, d_oe});
        host.xfer(1'b1, 1'b1, 4'h0, 8'h00, 20, rdat, got);
        check("vec_ack", 1, got);
        check("vec_data", 8'h7e, rdat);
        check("vec_oe", 0, {ack_oe, d_oe});
        // Write ended by select rising before acknowledge still lands the data held under select
        host.xfer(1'b0, 1'b0, 4'h3, 8'h11, 2, rdat, got);
        check("abort_wr", {20'h2, 4'h3, 8'h11}, {n_wr[19:0], last_wa, last_wr});
        // Strap low: no bus cycle at all
        strap = 1'b0;
        repeat (3) @(negedge core_clk);
        check("strap_ack", 0, bm_ack);
        host.xfer(1'b0, 1'b1, 4'h5, 8'h00, 12, rdat, got);
        check("strap_cycle", 0, got);
        strap = 1'b1;
        // Both reset inputs park the port high and float the bus
        fn.irq_pin_en = 4'hf;
        st = 8'hff;
        msk = 8'hff;
        for (int i = 0; i < 2; i++) begin
            opv = 8'hff;
            repeat (2) @(negedge core_clk);
            rst = (i == 0);
            reset_in_n = (i != 0) ? 1'b0 : 1'b1;
            @(negedge core_clk);
            check("rst_port", 16'hffff, {op_out, op_oe});
            check("rst_bus", 0, {ack_oe, d_oe, wr_s, rd_s, irq_oe});
            rst = 1'b0;
            reset_in_n = 1'b1;
        end
        results();
    end
endmodule : host_bus_pins_bench
`default_nettype wire

// ===== verif/host_cpu_model.sv
// Host processor model driving the acknowledge-style bus
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model
    import host_pins_pkg::*;
(
    // Bus as seen by the host
    input wire logic core_clk,
    input wire logic ack_wire,
    input wire logic [DATA_W-1:0] d_bus,
    output logic chip_select_n,
    output logic read_write_select,
    output logic irq_ack_in_n,
    output logic [ADDR_W-1:0] addr,
    output logic [DATA_W-1:0] data_in
);
    // Idle: both selects high
    initial begin
        chip_select_n = 1'b1;
        read_write_select = 1'b1;
        irq_ack_in_n = 1'b1;
        addr = 4'h0;
        data_in = 8'h00;
    end
    // One transfer; request held until acknowledge is sampled or lim edges pass
    task automatic xfer(input logic vec, input logic rd, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] wd, input int lim, output logic [DATA_W-1:0] rdat, output logic got);
        int n;
        n = 0;
        got = 1'b0;
        rdat = 8'h00;
        @(negedge core_clk);
        addr = a;
        read_write_select = rd;
        data_in = rd ? ~data_in : wd; // Released lines show the inverse, not stale data
        chip_select_n = vec;
        irq_ack_in_n = ~vec;
        while (!got && n < lim) begin
            @(posedge core_clk);
            n++;
            if (ack_wire === 1'b0) begin
                got = 1'b1;
                rdat = d_bus;
            end
        end
        // Release, then give the handshake time to return to idle
        @(negedge core_clk);
        chip_select_n = 1'b1;
        irq_ack_in_n = 1'b1;
        addr = ~addr;
        data_in = ~data_in;
        repeat (4) @(negedge core_clk);
    endtask : xfer
endmodule : host_cpu_model
`default_nettype wire
